// ### cln_regs.svh
// Timing, command and sequence constants for the character display nibble driver
`ifndef CLN_REGS_SVH
`define CLN_REGS_SVH

// ****************************************************************
// Clock and time figures
// ****************************************************************
`define CLN_CLK_PERIOD_NS 100
`define CLN_SETUP_NS      40
`define CLN_PULSE_NS      230
`define CLN_NIB_GAP_NS    1000
`define CLN_BYTE_GAP_NS   40000
`define CLN_CLEAR_NS      1640000
`define CLN_POWER_NS      15000000
`define CLN_INIT1_NS      4100000
`define CLN_INIT2_NS      100000
`define CLN_INIT3_NS      40000

// Least time to whole cycles, rounded up
`define CLN_NS_TO_CYC(ns) (((ns) + `CLN_CLK_PERIOD_NS - 1) / `CLN_CLK_PERIOD_NS)

`define CLN_SETUP_CYC   `CLN_NS_TO_CYC(`CLN_SETUP_NS)
`define CLN_PULSE_CYC   `CLN_NS_TO_CYC(`CLN_PULSE_NS)
`define CLN_NIB_GAP_CYC `CLN_NS_TO_CYC(`CLN_NIB_GAP_NS)
`define CLN_BYTE_CYC    `CLN_NS_TO_CYC(`CLN_BYTE_GAP_NS)
`define CLN_INIT2_CYC   `CLN_NS_TO_CYC(`CLN_INIT2_NS)
`define CLN_INIT3_CYC   `CLN_NS_TO_CYC(`CLN_INIT3_NS)

// ****************************************************************
// Nibbles and command bytes
// ****************************************************************
`define CLN_NIB_WAKE     4'h3
`define CLN_NIB_4BIT     4'h2
`define CLN_NIB_PARK     4'h0
`define CLN_CMD_FUNC_SET 8'h28
`define CLN_CMD_ENTRY    8'h06
`define CLN_CMD_DISP_ON  8'h0C
`define CLN_CMD_CLEAR    8'h01
`define CLN_CMD_HOME     8'h02
`define CLN_CMD_SET_ADDR 8'h80

// ****************************************************************
// Start-up sequence steps
// ****************************************************************
`define CLN_SEQ_INIT0    4'h0
`define CLN_SEQ_INIT1    4'h1
`define CLN_SEQ_INIT2    4'h2
`define CLN_SEQ_INIT3    4'h3
`define CLN_SEQ_FUNC     4'h4
`define CLN_SEQ_ENTRY    4'h5
`define CLN_SEQ_DISP     4'h6
`define CLN_SEQ_CLEAR    4'h7
`define CLN_SEQ_ADDR     4'h8
`define CLN_SEQ_RUN      4'h9

`endif

// ### cln_pkg.sv
// Types shared by the character display nibble driver
package cln_pkg;

  // Nibble engine states
  typedef enum logic [2:0] {
    CLN_ST_POWER,
    CLN_ST_SETUP,
    CLN_ST_PULSE,
    CLN_ST_GAP,
    CLN_ST_IDLE
  } cln_state_e;

endpackage

// ### cln_buffer.sv
// Two-entry valid/ready buffer in front of the nibble engine
`timescale 1ns/1ns
`include "cln_regs.svh"

module cln_buffer
  import cln_pkg::*;
#(
  parameter int WIDTH = 9,
  parameter int DEPTH = 2
)
(
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  output logic                  out_valid,
  output logic      [WIDTH-1:0] out_data,
  input  wire logic             out_ready
);

  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CNT_W = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PTR_W-1:0] wr_ptr_reg, wr_ptr_next;
  logic [PTR_W-1:0] rd_ptr_reg, rd_ptr_next;
  logic [CNT_W-1:0] count_reg, count_next;
  logic             in_ready_reg, in_ready_next;
  logic             out_valid_reg, out_valid_next;
  logic             push;
  logic             pop;

  assign push      = in_valid && in_ready_reg;
  assign pop       = out_ready && out_valid_reg;
  assign in_ready  = in_ready_reg;
  assign out_valid = out_valid_reg;
  assign out_data  = mem_reg[rd_ptr_reg];

  // Pointer and fill level update
  always_comb
  begin
    wr_ptr_next = wr_ptr_reg;
    rd_ptr_next = rd_ptr_reg;
    count_next  = count_reg;
    if (push)
    begin
      wr_ptr_next = (wr_ptr_reg == PTR_W'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
    end
    if (pop)
    begin
      rd_ptr_next = (rd_ptr_reg == PTR_W'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
    end
    if (push && !pop)
    begin
      count_next = count_reg + 1'b1;
    end
    else if (pop && !push)
    begin
      count_next = count_reg - 1'b1;
    end
    in_ready_next  = (count_next != CNT_W'(DEPTH));
    out_valid_next = (count_next != '0);
  end

  // Control registers
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ptr_reg    <= '0;
      rd_ptr_reg    <= '0;
      count_reg     <= '0;
      in_ready_reg  <= 1'b1;
      out_valid_reg <= 1'b0;
    end
    else
    begin
      wr_ptr_reg    <= wr_ptr_next;
      rd_ptr_reg    <= rd_ptr_next;
      count_reg     <= count_next;
      in_ready_reg  <= in_ready_next;
      out_valid_reg <= out_valid_next;
    end
  end

  // Entry storage, one write port per entry
  for (genvar g = 0; g < DEPTH; g++)
  begin : g_entry
    always_ff @(posedge core_clk)
    begin
      if (push && (wr_ptr_reg == PTR_W'(g)))
      begin
        mem_reg[g] <= in_data;
      end
    end
  end

endmodule

// ### cln_driver.sv
// Host driver for a 16x2 character display on a 4-bit bus
`timescale 1ns/1ns
`include "cln_regs.svh"

module cln_driver
  import cln_pkg::*;
#(
  parameter logic [6:0]  START_ADDR = 7'h00,
  parameter int unsigned WAIT_W     = 18,
  parameter int unsigned POWER_CYC  = `CLN_NS_TO_CYC(`CLN_POWER_NS),
  parameter int unsigned INIT1_CYC  = `CLN_NS_TO_CYC(`CLN_INIT1_NS),
  parameter int unsigned CLEAR_CYC  = `CLN_NS_TO_CYC(`CLN_CLEAR_NS)
)
(
  input  wire logic       core_clk,
  input  wire logic       rst_b,
  input  wire logic       lcd_enable,
  input  wire logic       wr_valid,
  input  wire logic [7:0] wr_data,
  input  wire logic       wr_is_data,
  output logic            wr_ready,
  output logic            init_done,
  output logic      [3:0] lcd_nibble_bus,
  output logic            lcd_reg_select,
  output logic            lcd_read_write,
  output logic            lcd_strobe
);

  // ****************************************************************
  // Reset release
  // ****************************************************************
  logic rst_sync1_reg;
  logic rst_sync2_reg;
  logic rst_n;

  // Two-stage release of the asynchronous reset
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rst_sync1_reg <= 1'b0;
      rst_sync2_reg <= 1'b0;
    end
    else
    begin
      rst_sync1_reg <= 1'b1;
      rst_sync2_reg <= rst_sync1_reg;
    end
  end

  assign rst_n = rst_sync2_reg;

  // ****************************************************************
  // Input buffer
  // ****************************************************************
  logic       buf_valid;
  logic [8:0] buf_data;
  logic       buf_pop;

  cln_buffer #(
    .WIDTH (9),
    .DEPTH (2)
  ) u_buffer (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .in_valid  (wr_valid),
    .in_data   ({wr_is_data, wr_data}),
    .in_ready  (wr_ready),
    .out_valid (buf_valid),
    .out_data  (buf_data),
    .out_ready (buf_pop)
  );

  // ****************************************************************
  // Nibble engine
  // ****************************************************************
  cln_state_e        state_reg, state_next;
  logic [WAIT_W-1:0] cnt_reg, cnt_next;
  logic [3:0]        seq_reg, seq_next;
  logic [7:0]        byte_reg, byte_next;
  logic              byte_mode_reg, byte_mode_next;
  logic              low_reg, low_next;
  logic [3:0]        nib_reg, nib_next;
  logic              rs_reg, rs_next;
  logic              strobe_reg, strobe_next;
  logic              done_reg, done_next;
  logic [WAIT_W-1:0] wait_sel;
  logic              long_cmd;
  logic [3:0]        seq_inc;

  // Start-up step contents: the value sent at each step
  function automatic logic [7:0] step_value(input logic [3:0] s);
    case (s)
      `CLN_SEQ_INIT0: step_value = {4'h0, `CLN_NIB_WAKE};
      `CLN_SEQ_INIT1: step_value = {4'h0, `CLN_NIB_WAKE};
      `CLN_SEQ_INIT2: step_value = {4'h0, `CLN_NIB_WAKE};
      `CLN_SEQ_INIT3: step_value = {4'h0, `CLN_NIB_4BIT};
      `CLN_SEQ_FUNC:  step_value = `CLN_CMD_FUNC_SET;
      `CLN_SEQ_ENTRY: step_value = `CLN_CMD_ENTRY;
      `CLN_SEQ_DISP:  step_value = `CLN_CMD_DISP_ON;
      `CLN_SEQ_CLEAR: step_value = `CLN_CMD_CLEAR;
      default:        step_value = `CLN_CMD_SET_ADDR | {1'b0, START_ADDR};
    endcase
  endfunction

  assign seq_inc  = seq_reg + 4'h1;
  // Clear and home need the long execution wait
  assign long_cmd = !rs_reg && ((byte_reg == `CLN_CMD_CLEAR) || (byte_reg == `CLN_CMD_HOME));

  // Low time after the current pulse
  always_comb
  begin
    if (!byte_mode_reg)
    begin
      case (seq_reg)
        `CLN_SEQ_INIT0: wait_sel = WAIT_W'(INIT1_CYC);
        `CLN_SEQ_INIT1: wait_sel = WAIT_W'(`CLN_INIT2_CYC);
        default:        wait_sel = WAIT_W'(`CLN_INIT3_CYC);
      endcase
    end
    else if (!low_reg)
    begin
      wait_sel = WAIT_W'(`CLN_NIB_GAP_CYC);
    end
    else if (long_cmd)
    begin
      wait_sel = WAIT_W'(CLEAR_CYC);
    end
    else
    begin
      wait_sel = WAIT_W'(`CLN_BYTE_CYC);
    end
  end

  // Engine next state and pin values
  always_comb
  begin
    state_next     = state_reg;
    cnt_next       = cnt_reg;
    seq_next       = seq_reg;
    byte_next      = byte_reg;
    byte_mode_next = byte_mode_reg;
    low_next       = low_reg;
    nib_next       = nib_reg;
    rs_next        = rs_reg;
    strobe_next    = 1'b0;
    done_next      = done_reg;
    buf_pop        = 1'b0;
    case (state_reg)
      CLN_ST_POWER:
      begin
        cnt_next = cnt_reg - 1'b1;
        if (cnt_reg == '0)
        begin
          byte_next      = step_value(`CLN_SEQ_INIT0);
          byte_mode_next = 1'b0;
          nib_next       = byte_next[3:0];
          state_next     = CLN_ST_SETUP;
          cnt_next       = WAIT_W'(`CLN_SETUP_CYC - 1);
        end
      end
      CLN_ST_SETUP:
      begin
        cnt_next = cnt_reg - 1'b1;
        if (cnt_reg == '0)
        begin
          state_next  = CLN_ST_PULSE;
          strobe_next = 1'b1;
          cnt_next    = WAIT_W'(`CLN_PULSE_CYC - 1);
        end
      end
      CLN_ST_PULSE:
      begin
        strobe_next = 1'b1;
        cnt_next    = cnt_reg - 1'b1;
        if (cnt_reg == '0)
        begin
          strobe_next = 1'b0;
          state_next  = CLN_ST_GAP;
          cnt_next    = wait_sel - 1'b1;
        end
      end
      CLN_ST_GAP:
      begin
        cnt_next = cnt_reg - 1'b1;
        if (cnt_reg == '0)
        begin
          if (byte_mode_reg && !low_reg)
          begin
            low_next   = 1'b1;
            nib_next   = byte_reg[3:0];
            state_next = CLN_ST_SETUP;
            cnt_next   = WAIT_W'(`CLN_SETUP_CYC - 1);
          end
          else if (seq_reg < `CLN_SEQ_ADDR)
          begin
            seq_next       = seq_inc;
            byte_next      = step_value(seq_inc);
            byte_mode_next = (seq_inc >= `CLN_SEQ_FUNC);
            low_next       = 1'b0;
            rs_next        = 1'b0;
            nib_next       = byte_mode_next ? byte_next[7:4] : byte_next[3:0];
            state_next     = CLN_ST_SETUP;
            cnt_next       = WAIT_W'(`CLN_SETUP_CYC - 1);
          end
          else
          begin
            seq_next   = `CLN_SEQ_RUN;
            done_next  = 1'b1;
            state_next = CLN_ST_IDLE;
          end
        end
      end
      CLN_ST_IDLE:
      begin
        if (buf_valid && lcd_enable)
        begin
          buf_pop        = 1'b1;
          byte_next      = buf_data[7:0];
          rs_next        = buf_data[8];
          byte_mode_next = 1'b1;
          low_next       = 1'b0;
          nib_next       = buf_data[7:4];
          state_next     = CLN_ST_SETUP;
          cnt_next       = WAIT_W'(`CLN_SETUP_CYC - 1);
        end
        else
        begin
          nib_next = `CLN_NIB_PARK;
          rs_next  = 1'b0;
        end
      end
      default:
      begin
        state_next = CLN_ST_POWER;
        cnt_next   = WAIT_W'(POWER_CYC - 1);
      end
    endcase
  end

  // Engine registers
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg     <= CLN_ST_POWER;
      cnt_reg       <= WAIT_W'(POWER_CYC - 1);
      seq_reg       <= `CLN_SEQ_INIT0;
      byte_reg      <= 8'h00;
      byte_mode_reg <= 1'b0;
      low_reg       <= 1'b0;
      nib_reg       <= `CLN_NIB_PARK;
      rs_reg        <= 1'b0;
      strobe_reg    <= 1'b0;
      done_reg      <= 1'b0;
    end
    else
    begin
      state_reg     <= state_next;
      cnt_reg       <= cnt_next;
      seq_reg       <= seq_next;
      byte_reg      <= byte_next;
      byte_mode_reg <= byte_mode_next;
      low_reg       <= low_next;
      nib_reg       <= nib_next;
      rs_reg        <= rs_next;
      strobe_reg    <= strobe_next;
      done_reg      <= done_next;
    end
  end

  // Pins straight from the engine flops; read/write never leaves write
  assign lcd_nibble_bus = nib_reg;
  assign lcd_reg_select = rs_reg;
  assign lcd_read_write = 1'b0;
  assign lcd_strobe     = strobe_reg;
  assign init_done      = done_reg;

  // ****************************************************************
  // Checks
  // ****************************************************************
  logic [WAIT_W-1:0] low_run_reg;
  logic              last_low_reg;
  logic              last_long_reg;
  logic              seen_pulse_reg;
  logic              high_rs_reg;

  // Low-time counter and facts about the previous pulse
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      low_run_reg    <= '0;
      last_low_reg   <= 1'b0;
      last_long_reg  <= 1'b0;
      seen_pulse_reg <= 1'b0;
      high_rs_reg    <= 1'b0;
    end
    else
    begin
      if (strobe_reg)
      begin
        low_run_reg    <= '0;
        last_low_reg   <= byte_mode_reg && low_reg;
        last_long_reg  <= byte_mode_reg && low_reg && long_cmd;         // Whole byte only
        seen_pulse_reg <= 1'b1;
        if (!low_reg)
        begin
          high_rs_reg <= rs_reg;
        end
      end
      else if (low_run_reg != '1)
      begin
        low_run_reg <= low_run_reg + 1'b1;
      end
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence strobe_pulse_s;
    strobe_reg [*3] ##1 !strobe_reg;
  endsequence

  sequence strobe_rise_s;
    !strobe_reg ##1 strobe_reg;
  endsequence

  strobe_width_a: assert property ($rose(strobe_reg) |-> strobe_pulse_s)
    else $error("strobe pulse not three cycles wide");
  setup_steady_a: assert property (strobe_rise_s |-> $stable(nib_reg) && $stable(rs_reg))
    else $error("bus changed at strobe rise");
  pulse_steady_a: assert property (strobe_reg && $past(strobe_reg) |-> $stable(nib_reg))
    else $error("nibble changed during strobe");
  write_only_a: assert property (!lcd_read_write)
    else $error("read/write left write");
  nibble_gap_a: assert property ($rose(strobe_reg) && seen_pulse_reg |->
      low_run_reg >= WAIT_W'(`CLN_NIB_GAP_CYC))
    else $error("nibble pulses too close");
  byte_gap_a: assert property ($rose(strobe_reg) && last_low_reg |->
      low_run_reg >= WAIT_W'(`CLN_BYTE_CYC))
    else $error("byte gap too short");
  clear_wait_a: assert property ($rose(strobe_reg) && last_long_reg |->
      low_run_reg >= WAIT_W'(CLEAR_CYC))
    else $error("clear wait too short");
  power_wait_a: assert property ($rose(strobe_reg) && !seen_pulse_reg |->
      low_run_reg >= WAIT_W'(POWER_CYC) && nib_reg == `CLN_NIB_WAKE)
    else $error("first nibble too early or wrong");
  init_wake_a: assert property ($rose(strobe_reg) && seq_reg == `CLN_SEQ_INIT1 |->
      low_run_reg >= WAIT_W'(INIT1_CYC) && nib_reg == `CLN_NIB_WAKE)
    else $error("second start-up nibble wrong");
  init_mode_a: assert property ($rose(strobe_reg) && seq_reg == `CLN_SEQ_INIT3 |->
      nib_reg == `CLN_NIB_4BIT)
    else $error("nibble mode step wrong");
  func_first_a: assert property ($rose(strobe_reg) && seq_reg == `CLN_SEQ_FUNC && !low_reg |->
      nib_reg == `CLN_CMD_FUNC_SET >> 4)
    else $error("first byte not function set");
  pair_select_a: assert property ($rose(strobe_reg) && byte_mode_reg && low_reg |->
      rs_reg == high_rs_reg)
    else $error("select differs between nibbles");
  park_idle_a: assert property (state_reg == CLN_ST_IDLE && !lcd_enable |=>
      !strobe_reg [*2])
    else $error("strobe raised while parked");

endmodule

// ### cln_lcd_model.sv
// Behavioural character display model with host timing checks
`timescale 1ns/1ns

module cln_lcd_model #(
  parameter int unsigned POWER_CYC = 150000,
  parameter int unsigned INIT1_CYC = 41000,
  parameter int unsigned CLEAR_CYC = 16400
)
(
  input  wire logic       core_clk,
  input  wire logic       rst_b,
  input  wire logic [3:0] lcd_nibble_bus,
  input  wire logic       lcd_reg_select,
  input  wire logic       lcd_read_write,
  input  wire logic       lcd_strobe,
  output int              viol_count,
  output int              pulse_count
);
  // ****************************************************************
  // Display state and pin monitor
  // ****************************************************************
  logic [7:0] ram      [0:127];
  logic [3:0] init_log [$];
  logic [8:0] byte_log [$];
  logic [6:0] addr_reg;
  logic [3:0] hi_reg;
  logic [3:0] prev_nib;
  logic       incr_reg;
  logic       half_reg;
  logic       long_reg;
  logic       rs_hi;
  logic       prev_rs;
  logic       prev_stb;
  int         high_cnt;
  int         gap_cnt;

  // Least low time owed before the next strobe
  function automatic int need_gap();
    case (pulse_count)
      0: return POWER_CYC;
      1: return INIT1_CYC;
      2: return 1000;
      3, 4: return 400;
      default: return half_reg ? 10 : (long_reg ? CLEAR_CYC : 400);
    endcase
  endfunction

  // Carry out one received byte
  task automatic exec(input logic rs, input logic [7:0] b);
    long_reg = !rs && (b == 8'h01 || b == 8'h02);
    if (rs)
    begin
      ram[addr_reg] = b; // Code kept as glyph index
      if (incr_reg) addr_reg = addr_reg + 7'h01; // No jump to line two
    end
    else if (b[7])
      addr_reg = b[6:0];
    else if (b == 8'h01)
    begin
      foreach (ram[i]) ram[i] = 8'h20;
      addr_reg = 7'h00;
    end
    else if (b == 8'h02)
      addr_reg = 7'h00;
    else if (b[7:2] == 6'h01)
      incr_reg = b[1];
  endtask

  // Sample pins, latch nibbles at strobe fall only
  always @(posedge core_clk or negedge rst_b)
    if (!rst_b)
    begin
      viol_count = 0;
      pulse_count = 0;
      gap_cnt = 0;
      high_cnt = 0;
      half_reg = 1'b0;
      long_reg = 1'b0;
      incr_reg = 1'b0;
      addr_reg = 7'h00;
      prev_stb = 1'b0;
    end
    else
    begin
      if (lcd_read_write !== 1'b0) viol_count++; // Write only
      if (lcd_strobe && !prev_stb)
      begin
        if (lcd_nibble_bus !== prev_nib || lcd_reg_select !== prev_rs) viol_count++;
        if (gap_cnt < need_gap()) viol_count++;
      end
      if (lcd_strobe) high_cnt++;
      else gap_cnt++;
      if (!lcd_strobe && prev_stb)
      begin
        if (high_cnt < 3) viol_count++;
        high_cnt = 0;
        gap_cnt = 1;
        if (pulse_count < 4) init_log.push_back(prev_nib);
        else if (!half_reg)
        begin
          hi_reg = prev_nib;
          rs_hi = prev_rs;
          half_reg = 1'b1;
        end
        else
        begin
          half_reg = 1'b0;
          if (prev_rs !== rs_hi) viol_count++;
          byte_log.push_back({prev_rs, hi_reg, prev_nib});
          exec(prev_rs, {hi_reg, prev_nib});
        end
        pulse_count++;
      end
      prev_stb = lcd_strobe;
      prev_nib = lcd_nibble_bus;
      prev_rs = lcd_reg_select;
    end
endmodule

// ### cln_driver_tb.sv
// Self-checking testbench for the character display nibble driver
`timescale 1ns/1ns

module cln_driver_tb;
  // ****************************************************************
  // Stimulus, expectation and checks
  // ****************************************************************
  localparam logic [6:0] START = 7'h05;
  localparam logic [3:0] INIT_NIB [4] = '{4'h3, 4'h3, 4'h3, 4'h2};
  logic       core_clk = 1'b0;
  logic       rst_b = 1'b0;
  logic       lcd_enable = 1'b1;
  logic       wr_valid = 1'b0;
  logic       wr_is_data = 1'b0;
  logic [7:0] wr_data = 8'h00;
  logic       wr_ready;
  logic       init_done;
  logic [3:0] lcd_nibble_bus;
  logic       lcd_reg_select;
  logic       lcd_read_write;
  logic       lcd_strobe;
  logic       saw_full = 1'b0;
  logic [7:0] exp_ram [0:127];
  logic [6:0] exp_addr = 7'h00;
  logic [8:0] exp_q [$];
  int         err_count = 0;
  int         checks_done = 0;
  int         viol_count;
  int         pulse_count;
  int         seed_val;
  int         np;

  always #50 core_clk = ~core_clk;

  cln_driver #(.START_ADDR(START), .POWER_CYC(200), .CLEAR_CYC(500))
  u_cln_driver (.core_clk(core_clk), .rst_b(rst_b), .lcd_enable(lcd_enable),
    .wr_valid(wr_valid), .wr_data(wr_data), .wr_is_data(wr_is_data), .wr_ready(wr_ready),
    .init_done(init_done), .lcd_nibble_bus(lcd_nibble_bus), .lcd_reg_select(lcd_reg_select),
    .lcd_read_write(lcd_read_write), .lcd_strobe(lcd_strobe));

  cln_lcd_model #(.POWER_CYC(200), .CLEAR_CYC(500))
  u_cln_lcd_model (.core_clk(core_clk), .rst_b(rst_b), .lcd_nibble_bus(lcd_nibble_bus),
    .lcd_reg_select(lcd_reg_select), .lcd_read_write(lcd_read_write),
    .lcd_strobe(lcd_strobe), .viol_count(viol_count), .pulse_count(pulse_count));

  // Note offers refused while the buffer is full
  always @(posedge core_clk) if (wr_valid && !wr_ready) saw_full <= 1'b1;

  // Shadow of the display contents and byte order
  function automatic void expect_byte(input logic rs, input logic [7:0] b);
    exp_q.push_back({rs, b});
    if (rs)
    begin
      exp_ram[exp_addr] = b;
      exp_addr = exp_addr + 7'h01;
    end
    else if (b[7])
      exp_addr = b[6:0];
    else if (b == 8'h01 || b == 8'h02)
    begin
      if (b == 8'h01) foreach (exp_ram[i]) exp_ram[i] = 8'h20;
      exp_addr = 7'h00;
    end
  endfunction

  task automatic check_val(input string name, input logic [8:0] exp, input logic [8:0] got);
    checks_done++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Offer one byte, held until taken; entered at a falling edge
  task automatic send_byte(input logic rs, input logic [7:0] b);
    int n;
    wr_valid = 1'b1;
    wr_data = b;
    wr_is_data = rs;
    n = 0;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (wr_ready !== 1'b1 && n < 20000);
    expect_byte(rs, b);
    @(negedge core_clk);
  endtask

  // Stop offering and let every byte reach the display
  task automatic drain();
    int n;
    wr_valid = 1'b0;
    n = 0;
    while (u_cln_lcd_model.byte_log.size() < exp_q.size() && n < 30000)
    begin
      @(posedge core_clk);
      n++;
    end
    repeat (600) @(negedge core_clk);
  endtask

  task automatic compare_all();
    check_val("byte count", 9'(exp_q.size()), 9'(u_cln_lcd_model.byte_log.size()));
    foreach (exp_q[i]) check_val("byte", exp_q[i], u_cln_lcd_model.byte_log[i]);
    for (int i = 0; i < 128; i++)
      check_val("ram", {1'b0, exp_ram[i]}, {1'b0, u_cln_lcd_model.ram[i]});
  endtask

  task automatic complete_run();
    $display("Counts: %0d checks, %0d mismatches", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Watchdog against a hang
  initial
  begin
    #(100 * 90000);
    err_count++;
    $display("watchdog expired");
    complete_run();
  end

  initial
  begin
    seed_val = $urandom(32'h0000CB3A);
    repeat (8) @(negedge core_clk);
    rst_b = 1'b1;
    np = 0;
    while (init_done !== 1'b1 && np < 60000)
    begin
      @(negedge core_clk);
      np++;
    end
    check_val("init done", 9'h001, {8'h00, init_done});
    expect_byte(1'b0, 8'h28);
    expect_byte(1'b0, 8'h06);
    expect_byte(1'b0, 8'h0C);
    expect_byte(1'b0, 8'h01);
    expect_byte(1'b0, {1'b1, START});
    drain();
    for (int i = 0; i < 4; i++)
      check_val("init nibble", {5'h00, INIT_NIB[i]}, {5'h00, u_cln_lcd_model.init_log[i]});
    compare_all();
    $display("test startup done");
    for (int i = 0; i < 20; i++)
      send_byte(1'b1, 8'($urandom()));
    drain();
    check_val("refused when full", 9'h001, {8'h00, saw_full});
    check_val("ready after drain", 9'h001, {8'h00, wr_ready});
    compare_all();
    $display("test characters done");
    send_byte(1'b0, 8'hC0);
    for (int i = 0; i < 4; i++)
      send_byte(1'b1, 8'($urandom()));
    send_byte(1'b0, 8'h02);
    send_byte(1'b1, 8'($urandom()));
    send_byte(1'b0, 8'h01);
    send_byte(1'b1, 8'($urandom()));
    drain();
    compare_all();
    $display("test commands done");
    lcd_enable = 1'b0;
    np = pulse_count;
    send_byte(1'b1, 8'h41);
    wr_valid = 1'b0;
    repeat (600) @(negedge core_clk);
    check_val("parked pulses", 9'(np), 9'(pulse_count));
    check_val("parked pins", 9'h000,
      {2'b00, lcd_strobe, lcd_read_write, lcd_reg_select, lcd_nibble_bus});
    lcd_enable = 1'b1;
    drain();
    compare_all();
    $display("test park done");
    check_val("timing faults", 9'h000, 9'(viol_count));
    complete_run();
  end
endmodule
